//--- rtl/wkm_pkg.sv
// package for the wake-up source manager: constants, types and field layout
// assumes a single slow always-on clock and a synchronous power-on reset
// Behaviour
// - all wake-up sources are treated alike, with no arbitration order.
// - the first valid event on an enabled source starts the wake sequence.
// - each firing source latches its own flag, even after wake began.
// - software clears each latched flag by a write.
// - no event is lost; a set in the same cycle as its clear wins.
// - after power-on reset only bus wake and monitor inputs are enabled.
// - after power-on reset every port pin is disabled as a wake-up source.
// - software enables or disables each source individually.
// - each monitor and port input selects rising, falling or both edges.
// - stop mode drops the core pll and stops, not unpowers, the core.
// - the measurement unit is on throughout active, off in stop and sleep.
// - wake-up and cyclic logic run on the always-on slow clock.
package wkm_pkg;
    localparam int WKM_N_MON = 4;
    localparam int WKM_N_PORT = 11;
    // source vector layout: bit 0 bus wake, then monitors, then port pins
    localparam int WKM_BUS_POS = 0;
    localparam int WKM_MON_POS = 1;
    localparam int WKM_PORT_POS = WKM_MON_POS + WKM_N_MON;
    localparam int WKM_N_SRC = WKM_PORT_POS + WKM_N_PORT;
    localparam logic [WKM_N_SRC-1:0] WKM_EN_RST = 16'h001f;
    localparam logic [WKM_N_SRC-1:0] WKM_FLAG_RST = 16'h0000;
    // sequence length in slow clock cycles before wake is signalled done
    localparam logic [3:0] WKM_SEQ_CYC = 4'h4;
    localparam logic [3:0] WKM_CNT_RST = 4'h0;

    typedef enum logic [1:0] {
        WKM_EDGE_RISE = 2'h1,
        WKM_EDGE_FALL = 2'h2,
        WKM_EDGE_BOTH = 2'h3
    } wkm_edge_e;

    typedef enum logic [1:0] {
        WKM_MODE_ACTIVE = 2'h0,
        WKM_MODE_STOP = 2'h1,
        WKM_MODE_SLEEP = 2'h2
    } wkm_mode_e;

    typedef enum logic [1:0] {
        WKM_CYC_OFF = 2'h0,
        WKM_CYC_WAKE = 2'h1,
        WKM_CYC_SENSE = 2'h2
    } wkm_cyc_e;

    typedef enum logic [2:0] {
        WKM_ST_RUN = 3'h1,
        WKM_ST_LOWP = 3'h2,
        WKM_ST_WAKE = 3'h4
    } wkm_st_e;

    // edge select decode, used only by the edge detector
    function automatic logic wkm_edge_hit(input logic [1:0] sel,
                                          input logic prev,
                                          input logic cur);
        wkm_edge_hit = (sel[0] & ~prev & cur) | (sel[1] & prev & ~cur);
    endfunction : wkm_edge_hit
endpackage : wkm_pkg

//--- rtl/wkm_sync.sv
// two-flop synchroniser bank for the asynchronous wake inputs
// assumes inputs may change at any time relative to i_clk_sys
`timescale 1ns/1ps
module wkm_sync
    import wkm_pkg::*;
#(
    parameter int W = WKM_N_SRC
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic [W-1:0] i_async,
    input wire logic [W-1:0] i_rst_val,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // reset loads the idle level tied by the parent, so no false edge follows
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            meta_q <= i_rst_val;
            sync_q <= i_rst_val;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule : wkm_sync

//--- rtl/wkm_edge.sv
// per-source edge detector on synchronised inputs
// assumes inputs are already in the i_clk_sys domain
`timescale 1ns/1ps
module wkm_edge
    import wkm_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic [WKM_N_SRC-1:0] i_sig,
    input wire logic [2*WKM_N_SRC-1:0] i_sel,
    output logic [WKM_N_SRC-1:0] o_hit
);
    logic [WKM_N_SRC-1:0] prev_q;
    logic primed_q;
    logic [WKM_N_SRC-1:0] hit_w;

    // first cycle after reset only seeds history, avoiding a spurious edge
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            prev_q <= '0;
            primed_q <= 1'b0;
        end else begin
            prev_q <= i_sig;
            primed_q <= 1'b1;
        end
    end

    for (genvar g = 0; g < WKM_N_SRC; g++) begin : g_hit
        assign hit_w[g] = primed_q
            & wkm_edge_hit(i_sel[2*g +: 2], prev_q[g], i_sig[g]);
    end
    assign o_hit = hit_w;
endmodule : wkm_edge

//--- rtl/wkm_top.sv
// wake-up source manager: source enables, edge events, sticky flags,
// wake sequence and per-mode gating outputs
// assumes i_clk_sys is the always-on slow clock and i_sys_rst is power-on
// reset; config and clear inputs come from software logic on this clock
`timescale 1ns/1ps
module wkm_top
    import wkm_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_bus_wake,
    input wire logic [WKM_N_MON-1:0] i_monitor_input,
    input wire logic [WKM_N_PORT-1:0] i_port_pin,
    input wire logic [WKM_N_SRC-1:0] i_en_wdata,
    input wire logic i_en_we,
    input wire logic [2*WKM_N_SRC-1:0] i_edge_wdata,
    input wire logic i_edge_we,
    input wire logic [WKM_N_SRC-1:0] i_flag_clr,
    input wire logic [1:0] i_mode_req,
    input wire logic [1:0] i_cyc_cfg,
    input wire logic i_wake_ack,
    output logic [WKM_N_SRC-1:0] o_src_en,
    output logic [WKM_N_SRC-1:0] o_flags,
    output logic o_wake_start,
    output logic o_wake_busy,
    output logic [1:0] o_mode,
    output logic [1:0] o_cyc_mode,
    output logic o_core_pll_en,
    output logic o_core_stopped,
    output logic o_core_power_en,
    output logic o_meas_unit_en
);
    logic [WKM_N_SRC-1:0] raw_w;
    logic [WKM_N_SRC-1:0] sync_w;
    logic [WKM_N_SRC-1:0] hit_w;
    logic [WKM_N_SRC-1:0] ev_w;
    logic [WKM_N_SRC-1:0] en_q;
    logic [2*WKM_N_SRC-1:0] edge_q;
    logic [WKM_N_SRC-1:0] flag_q;
    logic [WKM_N_SRC-1:0] flag_d;
    wkm_st_e st_q;
    wkm_st_e st_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic start_q;
    logic any_ev_w;
    logic [1:0] mode_q;
    logic [1:0] cyc_q;
    logic pll_q;
    logic stop_q;
    logic pwr_q;
    logic meas_q;
    logic lowp_w;
    logic busy_q;
    logic [WKM_N_SRC-1:0] clr_only_w;

    assign raw_w = {i_port_pin, i_monitor_input, i_bus_wake};

    wkm_sync #(
        .W(WKM_N_SRC)
    ) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_async(raw_w),
        .i_rst_val(WKM_FLAG_RST),
        .o_sync(sync_w)
    );

    wkm_edge u_edge (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_sig(sync_w),
        .i_sel(edge_q),
        .o_hit(hit_w)
    );

    // enables and edge selects; defaults: bus wake and monitors only
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            en_q <= WKM_EN_RST;
            edge_q <= {WKM_N_SRC{WKM_EDGE_BOTH}};
        end else begin
            if (i_en_we) begin
                en_q <= i_en_wdata;
            end
            if (i_edge_we) begin
                edge_q <= i_edge_wdata;
            end
        end
    end

    // flags latch every enabled source, in any state; set beats clear
    assign ev_w = hit_w & en_q;
    assign flag_d = (flag_q & ~i_flag_clr) | ev_w;
    assign any_ev_w = |ev_w;
    assign clr_only_w = i_flag_clr & ~ev_w;

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            flag_q <= WKM_FLAG_RST;
        end else begin
            flag_q <= flag_d;
        end
    end

    // low-power sequencer: a wake event in low power starts the sequence
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        case (st_q)
            WKM_ST_RUN: begin
                cnt_d = WKM_CNT_RST;
                if (i_mode_req != WKM_MODE_ACTIVE && !any_ev_w) begin
                    st_d = WKM_ST_LOWP;
                end
            end
            WKM_ST_LOWP: begin
                if (any_ev_w) begin
                    st_d = WKM_ST_WAKE;
                end else if (i_mode_req == WKM_MODE_ACTIVE) begin
                    // a request withdrawn before any event goes back to run
                    st_d = WKM_ST_RUN;
                end
            end
            WKM_ST_WAKE: begin
                if (cnt_q != WKM_SEQ_CYC) begin
                    cnt_d = cnt_q + 4'h1;
                end else if (i_wake_ack) begin
                    st_d = WKM_ST_RUN;
                end
            end
            default: begin
                st_d = WKM_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            st_q <= WKM_ST_RUN;
            cnt_q <= WKM_CNT_RST;
            start_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            start_q <= (st_q == WKM_ST_LOWP) && any_ev_w;
            busy_q <= (st_d == WKM_ST_WAKE);
        end
    end

    // gating returns to active one edge after the wake sequence starts;
    // a withdrawn request never leaves active with the measurement unit off
    assign lowp_w = (st_q == WKM_ST_LOWP) && (i_mode_req != WKM_MODE_ACTIVE);

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            mode_q <= WKM_MODE_ACTIVE;
            cyc_q <= WKM_CYC_OFF;
            pll_q <= 1'b1;
            stop_q <= 1'b0;
            pwr_q <= 1'b1;
            meas_q <= 1'b1;
        end else begin
            mode_q <= lowp_w ? i_mode_req : WKM_MODE_ACTIVE;
            // cyclic operation only outside active; reserved codes read off
            cyc_q <= (lowp_w && i_cyc_cfg != 2'h3) ? i_cyc_cfg
                                                   : WKM_CYC_OFF;
            pll_q <= !lowp_w;
            stop_q <= lowp_w && i_mode_req == WKM_MODE_STOP;
            pwr_q <= !(lowp_w && i_mode_req == WKM_MODE_SLEEP);
            meas_q <= !lowp_w; // no software off in active
        end
    end

    assign o_src_en = en_q;
    assign o_flags = flag_q;
    assign o_wake_start = start_q;
    assign o_wake_busy = busy_q;
    assign o_mode = mode_q;
    assign o_cyc_mode = cyc_q;
    assign o_core_pll_en = pll_q;
    assign o_core_stopped = stop_q;
    assign o_core_power_en = pwr_q;
    assign o_meas_unit_en = meas_q;

    // assertions
    sequence s_event;
        any_ev_w && st_q == WKM_ST_LOWP;
    endsequence
    sequence s_start;
        o_wake_start ##1 o_wake_busy;
    endsequence

    // the wake sequence counts four cycles before it looks at the ack
    sequence s_busy_min;
        o_wake_busy [*5];
    endsequence
    sequence s_woken;
        o_mode == WKM_MODE_ACTIVE && o_core_pll_en && o_meas_unit_en;
    endsequence

    // flags
    flag_set_a: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        |ev_w |-> ##1 ((o_flags & $past(ev_w)) == $past(ev_w)))
        else $error("event flag not latched");
    flag_clr_a: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (i_flag_clr[0] && !ev_w[0]) |=> !o_flags[0])
        else $error("flag not cleared");
    clr_all_a: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (|clr_only_w) |=> ((o_flags & $past(clr_only_w)) == '0))
        else $error("cleared flag still set");
    flag_hold_a: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (o_flags[1] && !i_flag_clr[1]) |=> o_flags[1])
        else $error("flag dropped without clear");
    flag_new_a: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (ev_w == '0) |=> ((o_flags & ~$past(o_flags)) == '0))
        else $error("flag set without an event");

    // wake sequence
    wake_start_a: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        s_event |=> s_start)
        else $error("wake sequence not started");
    start_pulse_a: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        o_wake_start |=> !o_wake_start)
        else $error("start is not a single pulse");
    start_busy_a: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        o_wake_start |-> o_wake_busy)
        else $error("start without busy");
    run_start_a: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (st_q == WKM_ST_RUN) |=> !o_wake_start)
        else $error("wake start outside low power");
    busy_len_a: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        $rose(o_wake_busy) |-> s_busy_min)
        else $error("wake sequence too short");
    busy_hold_a: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (o_wake_busy && !i_wake_ack) |=> o_wake_busy)
        else $error("wake sequence ended without ack");
    wake_mode_a: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        o_wake_start |=> s_woken)
        else $error("gating not active after wake start");

    // enables and edge selects
    dis_src_a: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (!o_src_en[WKM_PORT_POS] && !o_flags[WKM_PORT_POS]
         && !i_en_we) |=> !o_flags[WKM_PORT_POS])
        else $error("disabled source set flag");
    en_write_a: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        i_en_we |=> (o_src_en == $past(i_en_wdata)))
        else $error("enable write lost");
    edge_write_a: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        i_edge_we |=> (edge_q == $past(i_edge_wdata)))
        else $error("edge select write lost");
    rst_en_a: assert property (
        @(posedge i_clk_sys)
        $fell(i_sys_rst) |-> o_src_en == WKM_EN_RST)
        else $error("wrong default enables");
    rst_port_a: assert property (
        @(posedge i_clk_sys)
        $fell(i_sys_rst) |-> (o_src_en[WKM_N_SRC-1:WKM_PORT_POS] == '0))
        else $error("port pin enabled after reset");

    // per-mode gating
    active_cyc_a: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        o_mode == WKM_MODE_ACTIVE |-> o_cyc_mode == WKM_CYC_OFF)
        else $error("cyclic mode in active");
    wake_cyc_a: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        o_wake_start |=> (o_cyc_mode == WKM_CYC_OFF))
        else $error("cyclic mode left on after wake");
    meas_on_a: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        o_mode == WKM_MODE_ACTIVE |-> o_meas_unit_en)
        else $error("measurement unit off in active");
    meas_off_a: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (o_mode != WKM_MODE_ACTIVE) |-> !o_meas_unit_en)
        else $error("measurement unit on in low power");
    stop_pll_a: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        o_mode == WKM_MODE_STOP |-> !o_core_pll_en && o_core_stopped
            && o_core_power_en)
        else $error("stop mode core gating wrong");
    stop_only_a: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        o_core_stopped |-> (o_mode == WKM_MODE_STOP))
        else $error("core stopped outside stop mode");
    sleep_pwr_a: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (o_mode == WKM_MODE_SLEEP) |-> (!o_core_power_en && !o_core_pll_en))
        else $error("sleep mode core gating wrong");
endmodule : wkm_top

//--- sim/wkm_core_model.sv
// core-side model that acknowledges the end of a wake sequence
// assumes busy is a level from the manager on the same slow clock
`timescale 1ns/1ps
module wkm_core_model (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_busy,
    input wire logic i_slow,
    output logic o_ack
);
    logic [3:0] wait_q;
    logic [3:0] wait_d;
    // saturate so a stuck busy never wraps back to an early ack
    assign wait_d = (wait_q == 4'hf) ? wait_q : wait_q + 4'h1;
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || !i_busy) begin
            wait_q <= 4'h0;
            o_ack <= 1'b0;
        end else begin
            wait_q <= wait_d;
            o_ack <= (wait_q >= (i_slow ? 4'hc : 4'h5));
        end
    end
endmodule : wkm_core_model

//--- sim/test_wake_up_source_manager.sv
// self-checking bench for the wake-up source manager
// assumes one slow clock; async pins are toggled by this bench directly
`timescale 1ns/1ps
module test_wake_up_source_manager;
    import wkm_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [15:0] src_q = 16'h0000;
    logic [15:0] en_wdata = 16'h0000;
    logic en_we = 1'b0;
    logic [31:0] edge_wdata = 32'h0;
    logic edge_we = 1'b0;
    logic [15:0] flag_clr = 16'h0000;
    logic [1:0] mode_req = 2'h0;
    logic [1:0] cyc_cfg = 2'h1;
    logic slow = 1'b0;
    logic ack;
    logic [15:0] src_en, flags;
    logic wake_start, wake_busy, pll_en, stopped, power_en, meas_en;
    logic [1:0] mode, cyc_mode;
    int fail_count = 0;
    int compares = 0;
    int a, b, code, c;
    logic rise, seen;
    logic [15:0] rnd_en;

    wkm_top uut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
        .i_bus_wake(src_q[0]), .i_monitor_input(src_q[4:1]),
        .i_port_pin(src_q[15:5]), .i_en_wdata(en_wdata), .i_en_we(en_we),
        .i_edge_wdata(edge_wdata), .i_edge_we(edge_we),
        .i_flag_clr(flag_clr), .i_mode_req(mode_req), .i_cyc_cfg(cyc_cfg),
        .i_wake_ack(ack), .o_src_en(src_en), .o_flags(flags),
        .o_wake_start(wake_start), .o_wake_busy(wake_busy), .o_mode(mode),
        .o_cyc_mode(cyc_mode), .o_core_pll_en(pll_en),
        .o_core_stopped(stopped), .o_core_power_en(power_en),
        .o_meas_unit_en(meas_en));
    wkm_core_model partner (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
        .i_busy(wake_busy), .i_slow(slow), .o_ack(ack));

    initial begin
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end

    function automatic logic exp_hit(input logic [1:0] sel, input logic up);
        return up ? sel[0] : sel[1];
    endfunction : exp_hit

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask : tick

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    // one edge on a pin, then long enough for sync plus flag latch
    task automatic pulse_src(input int idx);
        @(posedge i_clk_sys) src_q[idx] <= ~src_q[idx];
        tick(4);
        @(negedge i_clk_sys);
    endtask : pulse_src

    task automatic clear_all;
        @(posedge i_clk_sys) flag_clr <= 16'hffff;
        @(posedge i_clk_sys) flag_clr <= 16'h0000;
        @(negedge i_clk_sys);
    endtask : clear_all

    task automatic write_cfg(input logic [15:0] en, input logic [31:0] sel);
        @(posedge i_clk_sys) begin
            en_wdata <= en;
            en_we <= 1'b1;
            edge_wdata <= sel;
            edge_we <= 1'b1;
        end
        @(posedge i_clk_sys) begin
            en_we <= 1'b0;
            edge_we <= 1'b0;
        end
        @(negedge i_clk_sys);
    endtask : write_cfg

    // start selects the one-cycle start pulse, else waits for busy to end
    task automatic wait_for(input bit start);
        for (int n = 0; n < 40; n++) begin
            @(negedge i_clk_sys);
            if (start ? (wake_start === 1'b1) : (wake_busy === 1'b0)) return;
        end
        chk(0, 1, "wait timed out");
        tally_and_finish();
    endtask : wait_for

    initial begin
        a = $urandom(32'h74fc);
        repeat (2) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        tick(2);
        @(negedge i_clk_sys);
        chk({src_en, flags}, {16'h001f, 16'h0000}, "reset enables");
        chk({mode, cyc_mode, pll_en, stopped, power_en, meas_en}, 8'h0b,
            "active gating");
        pulse_src(WKM_PORT_POS + $urandom_range(WKM_N_PORT - 1));
        chk(flags, 16'h0000, "port pin woke while disabled");
        a = $urandom_range(WKM_PORT_POS - 1);
        pulse_src(a);
        chk(flags, 16'h0001 << a, "default source flag");
        clear_all();
        chk(flags, 16'h0000, "flag clear");
        rnd_en = $urandom;
        write_cfg(rnd_en, 32'hffffffff);
        chk(src_en, rnd_en, "enable write");
        for (code = 1; code < 4; code++) begin
            write_cfg(16'hffff, {16{code[1:0]}});
            clear_all();
            a = $urandom_range(WKM_N_SRC - 1);
            rise = !src_q[a];
            pulse_src(a);
            chk(flags[a], exp_hit(code[1:0], rise), "first edge");
            pulse_src(a);
            chk(flags[a], exp_hit(code[1:0], rise) |
                exp_hit(code[1:0], !rise), "second edge");
        end
        // clear held through the event: the flag must still be seen set
        write_cfg(16'hffff, 32'hffffffff);
        a = $urandom_range(WKM_N_SRC - 1);
        seen = 1'b0;
        @(posedge i_clk_sys) flag_clr <= 16'hffff;
        @(posedge i_clk_sys) src_q[a] <= ~src_q[a];
        repeat (6) begin
            @(negedge i_clk_sys);
            seen = seen | flags[a];
        end
        @(posedge i_clk_sys) flag_clr <= 16'h0000;
        chk(seen, 1'b1, "event lost under clear");
        for (c = 0; c < 4; c++) begin
            clear_all();
            slow = c[1];
            @(posedge i_clk_sys) begin
                mode_req <= c[0] ? 2'h2 : 2'h1;
                cyc_cfg <= c[1:0];
            end
            tick(3);
            @(negedge i_clk_sys);
            chk({mode, cyc_mode, pll_en, power_en, meas_en},
                {mode_req, (c == 3) ? 2'h0 : c[1:0], 1'b0, !c[0], 1'b0},
                "low power gating");
            if (!c[0]) chk(stopped, 1'b1, "core stopped");
            a = $urandom_range(WKM_N_SRC - 1);
            b = (a + 1 + $urandom_range(WKM_N_SRC - 2)) % WKM_N_SRC;
            @(posedge i_clk_sys) src_q[a] <= ~src_q[a];
            wait_for(1'b1);
            chk({mode, pll_en, wake_busy}, {mode_req, 2'b01},
                "wake entry");
            @(posedge i_clk_sys) mode_req <= 2'h0;
            @(negedge i_clk_sys);
            chk({mode, pll_en, meas_en}, 4'h3, "wake gating");
            pulse_src(b);
            chk(flags, (16'h0001 << a) | (16'h0001 << b), "both flags");
            wait_for(1'b0);
            tick(2);
            @(negedge i_clk_sys);
            chk({mode, pll_en, meas_en}, 4'h3, "back to active");
        end
        tally_and_finish();
    end
endmodule : test_wake_up_source_manager
